// *** design/spicfg_pkg.sv ***
// What this block does
// - Serial clock divides by 32, 16, 8, 4
// - Peripheral interrupt reaches host only when enabled
// - Expansion interrupt output held deasserted on product
// - Bit order flag picks MSB-left or LSB-right
// - Status flag mirrors inverted peripheral interrupt input level (set while input low)
// - Interrupt flag read-only, clears itself, drives IRQ
// - Frame bit placement for send and receive
// - Line select maps to IRQ3, IRQ4, IRQ5, IRQ10
package spicfg_pkg;

  // ==========================================================
  // Register map
  localparam logic [3:0] SPICFG_OFF_STATUS = 4'h0;
  localparam logic [3:0] SPICFG_OFF_TXDATA = 4'h4;
  localparam logic [3:0] SPICFG_OFF_RXDATA = 4'h8;
  localparam int unsigned SPICFG_AW        = 4;

  // ==========================================================
  // Status and options fields
  localparam int unsigned SPICFG_SEL_LSB  = 6;
  localparam int unsigned SPICFG_RATE_LSB = 4;
  localparam int unsigned SPICFG_IEN_BIT  = 3;
  localparam int unsigned SPICFG_LBF_BIT  = 2;
  localparam int unsigned SPICFG_INT_BIT  = 1;
  localparam int unsigned SPICFG_BUSY_BIT = 0;
  localparam logic [7:0]  SPICFG_STATUS_RST = 8'h00;
  localparam int unsigned SPICFG_NUM_IRQ  = 4;

  // ==========================================================
  // Clock divider half periods, in aclk cycles
  localparam logic [4:0] SPICFG_HALF_DIV32 = 5'h10;
  localparam logic [4:0] SPICFG_HALF_DIV16 = 5'h08;
  localparam logic [4:0] SPICFG_HALF_DIV8  = 5'h04;
  localparam logic [4:0] SPICFG_HALF_DIV4  = 5'h02;

  localparam logic [1:0] SPICFG_RESP_OKAY   = 2'b00;
  localparam logic [1:0] SPICFG_RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    SPICFG_IDLE = 2'b00,
    SPICFG_LOW  = 2'b01,
    SPICFG_HIGH = 2'b10
  } spicfg_state_t;

  function automatic logic [4:0] spicfg_half(input logic [1:0] code);
    case (code)
      2'b00:   spicfg_half = SPICFG_HALF_DIV32;
      2'b01:   spicfg_half = SPICFG_HALF_DIV16;
      2'b10:   spicfg_half = SPICFG_HALF_DIV8;
      default: spicfg_half = SPICFG_HALF_DIV4;
    endcase
  endfunction

endpackage

// *** design/spicfg_top.sv ***
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

// ============================================================
// Transmit FIFO
module spicfg_fifo #(
  parameter int unsigned W     = 32,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW:0]  wr_ptr_r;
  logic [PW:0]  rd_ptr_r;

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least 2");
  end

  assign in_ready  = (wr_ptr_r - rd_ptr_r) != (PW + 1)'(DEPTH);
  assign out_valid = wr_ptr_r != rd_ptr_r;
  assign out_data  = mem[rd_ptr_r[PW-1:0]];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_r <= '0;
    end else if (ce && in_valid && in_ready) begin
      wr_ptr_r <= wr_ptr_r + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (ce && in_valid && in_ready) begin
      mem[wr_ptr_r[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_ptr_r <= '0;
    end else if (ce && out_valid && out_ready) begin
      rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
endmodule

// ============================================================
// SPI configuration, status and shift engine
module spicfg_top #(
  parameter int unsigned FRAME_W       = 32,
  parameter int unsigned FIFO_DEPTH    = 32,
  parameter bit          IRQ_CONNECTED = 1'b0
) (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic                           ce,
  input  wire logic [spicfg_pkg::SPICFG_AW-1:0] s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [spicfg_pkg::SPICFG_AW-1:0] s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  output logic                                sclk,
  output logic                                mosi,
  input  wire logic                           miso,
  input  wire logic                           peripheral_interrupt_in_n,
  output logic [spicfg_pkg::SPICFG_NUM_IRQ-1:0] host_irq
);
  import spicfg_pkg::*;

  if (FRAME_W < 2 || FRAME_W > 32) begin : g_bad_frame
    $error("FRAME_W must lie between 2 and 32");
  end

  logic [1:0]         irq_sel_r;
  logic [1:0]         rate_r;
  logic               irq_en_r;
  logic               lbf_r;
  logic               int_flag_r;
  logic               busy_r;
  logic               awready_r;
  logic               wready_r;
  logic               bvalid_r;
  logic [1:0]         bresp_r;
  logic               arready_r;
  logic               rvalid_r;
  logic [31:0]        rdata_r;
  logic [1:0]         rresp_r;
  logic [FRAME_W-1:0] rx_data_r;
  logic [FRAME_W-1:0] shift_r;
  logic [FRAME_W-1:0] shift_nxt;
  logic [5:0]         bit_cnt_r;
  logic [4:0]         half_r;
  logic [4:0]         tick_r;
  logic               lbf_cur_r;
  logic               sclk_r;
  logic               mosi_r;
  logic               miso_smp_r;
  logic [SPICFG_NUM_IRQ-1:0] host_irq_r;
  spicfg_state_t      state_r;

  logic               wr_fire;
  logic               rd_fire;
  logic               wr_ok;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic [31:0]        fifo_out_data;
  logic               load;
  logic [7:0]         status_w;

  // ==========================================================
  // AXI4-Lite write path
  // Stalling the address on a full FIFO pushes back to software.
  assign wr_ok   = (s_axi_awaddr != SPICFG_OFF_TXDATA) || fifo_in_ready;
  assign wr_fire = s_axi_awvalid && awready_r && s_axi_wvalid && wready_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
    end else if (ce) begin
      awready_r <= !awready_r && !bvalid_r && s_axi_awvalid && s_axi_wvalid && wr_ok;
      wready_r  <= !awready_r && !bvalid_r && s_axi_awvalid && s_axi_wvalid && wr_ok;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= SPICFG_RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        case (s_axi_awaddr)
          SPICFG_OFF_STATUS, SPICFG_OFF_TXDATA: bresp_r <= SPICFG_RESP_OKAY;
          default:                              bresp_r <= SPICFG_RESP_SLVERR;
        endcase
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Int flag and busy ignore writes; they are read-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_sel_r <= SPICFG_STATUS_RST[SPICFG_SEL_LSB +: 2];
      rate_r    <= SPICFG_STATUS_RST[SPICFG_RATE_LSB +: 2];
      irq_en_r  <= SPICFG_STATUS_RST[SPICFG_IEN_BIT];
      lbf_r     <= SPICFG_STATUS_RST[SPICFG_LBF_BIT];
    end else if (ce && wr_fire && s_axi_awaddr == SPICFG_OFF_STATUS && s_axi_wstrb[0]) begin
      irq_sel_r <= s_axi_wdata[SPICFG_SEL_LSB +: 2];
      rate_r    <= s_axi_wdata[SPICFG_RATE_LSB +: 2];
      irq_en_r  <= s_axi_wdata[SPICFG_IEN_BIT];
      lbf_r     <= s_axi_wdata[SPICFG_LBF_BIT];
    end
  end

  spicfg_fifo #(
    .W     (32),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .in_valid  (wr_fire && s_axi_awaddr == SPICFG_OFF_TXDATA),
    .in_ready  (fifo_in_ready),
    .in_data   (s_axi_wdata),
    .out_valid (fifo_out_valid),
    .out_ready (load),
    .out_data  (fifo_out_data)
  );

  // ==========================================================
  // AXI4-Lite read path
  always_comb begin
    status_w = '0;
    status_w[SPICFG_SEL_LSB +: 2]  = irq_sel_r;
    status_w[SPICFG_RATE_LSB +: 2] = rate_r;
    status_w[SPICFG_IEN_BIT]       = irq_en_r;
    status_w[SPICFG_LBF_BIT]       = lbf_r;
    status_w[SPICFG_INT_BIT]       = int_flag_r;
    status_w[SPICFG_BUSY_BIT]      = busy_r;
  end

  assign rd_fire = s_axi_arvalid && arready_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
    end else if (ce) begin
      arready_r <= !arready_r && !rvalid_r && s_axi_arvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= SPICFG_RESP_OKAY;
    end else if (ce) begin
      if (rd_fire) begin
        rvalid_r <= 1'b1;
        rresp_r  <= SPICFG_RESP_OKAY;
        case (s_axi_araddr)
          SPICFG_OFF_STATUS: rdata_r <= {24'h000000, status_w};
          SPICFG_OFF_RXDATA: rdata_r <= 32'(rx_data_r);
          default: begin
            rdata_r <= '0;
            rresp_r <= SPICFG_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Interrupt flag and host line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_flag_r <= 1'b0;
    end else if (ce) begin
      int_flag_r <= !peripheral_interrupt_in_n;
    end
  end

  // Line left unwired on this product; build flag enables it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_irq_r <= '0;
    end else if (ce) begin
      if (IRQ_CONNECTED && irq_en_r && int_flag_r) begin
        host_irq_r <= SPICFG_NUM_IRQ'(1) << irq_sel_r;
      end else begin
        host_irq_r <= '0;
      end
    end
  end

  // ==========================================================
  // Shift engine, clock idles low, sample on rising edge
  assign load = (state_r == SPICFG_IDLE) && fifo_out_valid;

  always_comb begin
    if (lbf_cur_r) begin
      shift_nxt = {miso_smp_r, shift_r[FRAME_W-1:1]};
    end else begin
      shift_nxt = {shift_r[FRAME_W-2:0], miso_smp_r};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r    <= SPICFG_IDLE;
      shift_r    <= '0;
      bit_cnt_r  <= '0;
      half_r     <= SPICFG_HALF_DIV32;
      tick_r     <= '0;
      lbf_cur_r  <= 1'b0;
      sclk_r     <= 1'b0;
      mosi_r     <= 1'b0;
      miso_smp_r <= 1'b0;
      rx_data_r  <= '0;
    end else if (ce) begin
      case (state_r)
        SPICFG_IDLE: begin
          if (load) begin
            shift_r   <= fifo_out_data[FRAME_W-1:0];
            half_r    <= spicfg_half(rate_r);
            tick_r    <= 5'h01;
            lbf_cur_r <= lbf_r;
            bit_cnt_r <= 6'(FRAME_W - 1);
            mosi_r    <= lbf_r ? fifo_out_data[0] : fifo_out_data[FRAME_W-1];
            state_r   <= SPICFG_LOW;
          end
        end
        SPICFG_LOW: begin
          if (tick_r == half_r) begin
            tick_r     <= 5'h01;
            sclk_r     <= 1'b1;
            miso_smp_r <= miso;
            state_r    <= SPICFG_HIGH;
          end else begin
            tick_r <= tick_r + 5'h01;
          end
        end
        SPICFG_HIGH: begin
          if (tick_r == half_r) begin
            tick_r  <= 5'h01;
            sclk_r  <= 1'b0;
            shift_r <= shift_nxt;
            mosi_r  <= lbf_cur_r ? shift_nxt[0] : shift_nxt[FRAME_W-1];
            if (bit_cnt_r == 6'h00) begin
              rx_data_r <= shift_nxt;
              state_r   <= SPICFG_IDLE;
            end else begin
              bit_cnt_r <= bit_cnt_r - 6'h01;
              state_r   <= SPICFG_LOW;
            end
          end else begin
            tick_r <= tick_r + 5'h01;
          end
        end
        default: state_r <= SPICFG_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_r <= 1'b0;
    end else if (ce) begin
      busy_r <= (state_r != SPICFG_IDLE) || fifo_out_valid;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign sclk          = sclk_r;
  assign mosi          = mosi_r;
  assign host_irq      = host_irq_r;

  // ==========================================================
  // Checks
  AST_DIV_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && load |=> half_r == spicfg_half($past(rate_r)))
    else $error("divider not loaded from rate select");
  AST_FAST_HIGH: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && $rose(sclk_r) && half_r == SPICFG_HALF_DIV4 && ce ##1 ce |=> !sclk_r)
    else $error("divide by four high time wrong");
  AST_IRQ_HELD: assert property (@(posedge aclk) disable iff (!aresetn)
    !IRQ_CONNECTED |-> host_irq_r == '0)
    else $error("unwired interrupt asserted");
  AST_IRQ_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !irq_en_r |=> host_irq_r == '0)
    else $error("interrupt passed while disabled");
  AST_IRQ_MAP: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && irq_en_r && int_flag_r |=>
      host_irq_r == (IRQ_CONNECTED ? (SPICFG_NUM_IRQ'(1) << $past(irq_sel_r)) : '0))
    else $error("wrong host line selected");
  AST_FLAG_TRACK: assert property (@(posedge aclk) disable iff (!aresetn)
    ce |=> int_flag_r == !$past(peripheral_interrupt_in_n))
    else $error("interrupt flag does not follow input");
  AST_FLAG_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && peripheral_interrupt_in_n ##1 ce && peripheral_interrupt_in_n |=> !int_flag_r)
    else $error("interrupt flag not cleared");
  AST_MSB_FIRST: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && load && !lbf_r |=> mosi_r == $past(fifo_out_data[FRAME_W-1]))
    else $error("MSB first order broken");
  AST_LSB_FIRST: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && load && lbf_r |=> mosi_r == $past(fifo_out_data[0]))
    else $error("LSB first order broken");
endmodule

// *** design/spicfg_unused_note.sv ***
`timescale 1ns/100ps

// *** tb/spicfg_periph_model.sv ***
`timescale 1ns/100ps

// ==========================================================
// SPI peripheral, mode 0, answering with a rotating word
module spicfg_periph_model #(
  parameter logic [31:0] PAT = 32'h3c96_0f5a
) (
  input  wire logic sclk,
  input  wire logic mosi,
  output logic      miso
);
  logic [31:0] pat_r = PAT;
  logic [31:0] cap_r = 32'h0000_0000;
  logic        armed_r = 1'b0;

  // Armed by a real rise, so the reset edge of sclk does not rotate
  always @(posedge sclk) begin
    cap_r   <= {cap_r[30:0], mosi};
    armed_r <= 1'b1;
  end

  // Next bit launched at the fall; a whole frame rotates back to start
  always @(negedge sclk) begin
    if (armed_r) begin
      pat_r <= {pat_r[30:0], pat_r[31]};
    end
  end

  assign miso = pat_r[31];
endmodule

// *** tb/test_spi_master_clock_shift_irq_config.sv ***
`timescale 1ns/100ps

module test_spi_master_clock_shift_irq_config;
  import spicfg_pkg::*;
  localparam logic [31:0] PAT        = 32'h3c96_0f5a;
  localparam logic [31:0] WORD       = 32'h81c3_5e27;
  localparam int          FIFO_DEPTH = 32;
  logic                 aclk = 1'b0;
  logic                 aresetn = 1'b0;
  logic [SPICFG_AW-1:0] awaddr = 4'h0;
  logic [SPICFG_AW-1:0] araddr = 4'h0;
  logic [31:0]          wdata = 32'h0;
  logic                 awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                 arvalid = 1'b0, rready = 1'b0, int_n = 1'b1;
  logic                 ce = 1'b1;
  logic [3:0]           strb = 4'hf;
  logic                 awready, wready, bvalid, arready, rvalid, sclk, mosi, miso;
  logic [1:0]           bresp, rresp;
  logic [31:0]          rdata;
  logic [3:0]           host_irq, host_irq_c;
  int                   errors = 0;
  int                   cmp_count = 0;

  always #5 aclk = ~aclk;

  // ==========================================================
  // Product build, and a build with the host lines wired
  spicfg_top #(.FIFO_DEPTH(FIFO_DEPTH)) dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sclk(sclk),
    .mosi(mosi), .miso(miso), .peripheral_interrupt_in_n(int_n), .host_irq(host_irq));

  // Shares every input, so it follows the same register writes
  spicfg_top #(.FIFO_DEPTH(FIFO_DEPTH), .IRQ_CONNECTED(1'b1)) dut_irq (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_wdata(wdata),
    .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(),
    .s_axi_bvalid(), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
    .s_axi_rvalid(), .s_axi_rready(rready), .sclk(), .mosi(), .miso(miso),
    .peripheral_interrupt_in_n(int_n), .host_irq(host_irq_c));

  spicfg_periph_model #(.PAT(PAT)) periph (.sclk(sclk), .mosi(mosi), .miso(miso));

  // ==========================================================
  // Shared tasks
  task automatic results;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic give_up(input string what);
    errors++;
    $display("unexpected at %0t: no answer on %s", $time, what);
    results();
  endtask

  function automatic logic [31:0] rev(input logic [31:0] x);
    for (int i = 0; i < 32; i++) rev[i] = x[31-i];
  endfunction

  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp,
                    output int n);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 1; n <= 3000; n++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n > 3000) give_up("write");
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 1; n <= 3000; n++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n > 3000) give_up("read");
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // Busy lags the push, so give it a few cycles before polling
  task automatic wait_idle;
    logic [31:0] d;
    logic [1:0]  r;
    repeat (4) @(posedge aclk);
    for (int k = 0; k < 3000; k++) begin
      rd(SPICFG_OFF_STATUS, d, r);
      if (d[SPICFG_BUSY_BIT] === 1'b0) return;
    end
    give_up("busy");
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    rd(SPICFG_OFF_STATUS, d, r);
    check(d, {24'h0, SPICFG_STATUS_RST}, "status after reset");
    wr(SPICFG_OFF_STATUS, 32'h0000_00ff, r, n);
    rd(SPICFG_OFF_STATUS, d, r);
    check(d, 32'h0000_00fc, "status readback");
    strb <= 4'he;
    wr(SPICFG_OFF_STATUS, 32'h0, r, n);
    strb <= 4'hf;
    rd(SPICFG_OFF_STATUS, d, r);
    check(d, 32'h0000_00fc, "write without byte lane 0 ignored");
    rd(4'hc, d, r);
    check({d[29:0], r}, {30'h0, SPICFG_RESP_SLVERR}, "unmapped read");
    wr(4'hc, 32'h0000_0001, r, n);
    check({30'h0, r}, {30'h0, SPICFG_RESP_SLVERR}, "unmapped write");
    rd(SPICFG_OFF_TXDATA, d, r);
    check({30'h0, r}, {30'h0, SPICFG_RESP_SLVERR}, "write-only read");
    wr(SPICFG_OFF_STATUS, 32'h0, r, n);
  endtask

  task automatic t_rate;
    logic [1:0] r;
    int         n;
    for (int c = 0; c < 4; c++) begin
      wr(SPICFG_OFF_STATUS, 32'(c) << SPICFG_RATE_LSB, r, n);
      wr(SPICFG_OFF_TXDATA, 32'h0, r, n);
      for (n = 0; n < 300 && sclk !== 1'b1; n++) @(negedge aclk);
      if (n == 300) give_up("sclk");
      for (n = 0; n < 100 && sclk === 1'b1; n++) @(negedge aclk);
      check(32'(n), 32'((32 >> c) / 2), "sclk high time");
      wait_idle();
    end
  endtask

  task automatic t_order;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    for (int b = 0; b < 2; b++) begin
      wr(SPICFG_OFF_STATUS, 32'h0000_0030 | (32'(b) << SPICFG_LBF_BIT), r, n);
      wr(SPICFG_OFF_TXDATA, WORD, r, n);
      wait_idle();
      rd(SPICFG_OFF_RXDATA, d, r);
      check(periph.cap_r, (b == 1) ? rev(WORD) : WORD, "sent order");
      check(d, (b == 1) ? rev(PAT) : PAT, "received order");
    end
  endtask

  // Freeze mid-frame; sclk must stand and the frame still finish intact
  task automatic t_freeze;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    int          moved;
    moved = 0;
    wr(SPICFG_OFF_STATUS, 32'h0, r, n);
    wr(SPICFG_OFF_TXDATA, WORD, r, n);
    for (n = 0; n < 300 && sclk !== 1'b1; n++) @(negedge aclk);
    if (n == 300) give_up("sclk");
    @(posedge aclk);
    ce <= 1'b0;
    repeat (60) begin
      @(posedge aclk);
      if (sclk !== 1'b1) moved++;
    end
    ce <= 1'b1;
    check(32'(moved), 32'h0, "sclk held while frozen");
    wait_idle();
    rd(SPICFG_OFF_RXDATA, d, r);
    check(periph.cap_r, WORD, "frozen frame sent");
    check(d, PAT, "frozen frame received");
  endtask

  task automatic t_irq;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    for (int s = 0; s < 4; s++) begin
      for (int e = 0; e < 2; e++) begin
        wr(SPICFG_OFF_STATUS, (32'(s) << SPICFG_SEL_LSB) | (32'(e) << SPICFG_IEN_BIT), r, n);
        int_n <= 1'b0;
        repeat (3) @(posedge aclk);
        rd(SPICFG_OFF_STATUS, d, r);
        check({31'h0, d[SPICFG_INT_BIT]}, 32'h1, "flag raised");
        check({28'h0, host_irq}, 32'h0, "product irq");
        check({28'h0, host_irq_c}, (e == 1) ? 32'h1 << s : 32'h0, "irq line");
        int_n <= 1'b1;
        repeat (3) @(posedge aclk);
        rd(SPICFG_OFF_STATUS, d, r);
        check({31'h0, d[SPICFG_INT_BIT]}, 32'h0, "flag cleared");
        check({28'h0, host_irq_c}, 32'h0, "irq dropped");
      end
    end
  endtask

  // Fastest rate; the engine pops too slowly to keep the queue from filling
  task automatic t_fill;
    logic [1:0] r;
    int         n;
    int         worst;
    worst = 0;
    wr(SPICFG_OFF_STATUS, 32'h0000_0030, r, n);
    for (int k = 0; k < FIFO_DEPTH + 4; k++) begin
      wr(SPICFG_OFF_TXDATA, 32'(k), r, n);
      if (n > worst) worst = n;
    end
    check({31'h0, worst > 20}, 32'h1, "full queue stalls write");
    wait_idle();
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_rate();
    t_order();
    t_freeze();
    t_irq();
    t_fill();
    results();
  end
endmodule
